// file: logic/usprx_exec.sv
// Executes user stack pushes, carry clear and procedure return.
// Contract
// RL1 - Decrementing push: pointer register minus one first
// RL2 - Then store source at new pointer address
// RL3 - Incrementing push: pointer register plus one first
// RL4 - Then store source at new pointer address
// RL5 - Pushes and return leave flags unchanged
// RL6 - Carry clear zeroes carry, other flags kept
// RL7 - Return pops PC high first, SP plus two
// RL8 - Next fetch from the new PC
// RL9 - Return takes eight, or ten cycles
// RL10 - PC low read from stack location plus one
`timescale 1ns/1ps
module usprx_exec
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire usprx_pkg::usprx_instr_t instr,
  input wire logic stack_external,
  input wire logic [7:0] stack_rd_data,
  output logic busy,
  output logic done,
  output logic [7:0] flags,
  output logic [15:0] pc,
  output logic [15:0] sp,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  output logic [15:0] stack_rd_addr,
  output logic [7:0] rf_dbg_data
);
  ////////////////////////////////////////////////////////////////////////
  usprx_pkg::usprx_state_t state_r;
  usprx_pkg::usprx_state_t state_nxt;
  usprx_pkg::usprx_instr_t ins_r;
  usprx_pkg::usprx_rf_wr_t wr;
  logic [3:0] cyc_r;
  logic [3:0] cyc_len_r;
  logic [7:0] ptr_r;
  logic [7:0] flags_r;
  logic [15:0] pc_r;
  logic [15:0] sp_r;
  logic [7:0] ret_hi_r;
  logic busy_r;
  logic done_r;
  logic fetch_r;
  logic [15:0] stk_addr_r;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  wire logic is_down;
  wire logic is_up;
  wire logic is_clr;
  wire logic is_ret;
  wire logic start;
  wire logic last_cyc;
  wire logic [7:0] ptr_new;

  assign is_down = instr.opcode == usprx_pkg::OP_PUSH_DOWN;
  assign is_up = instr.opcode == usprx_pkg::OP_PUSH_UP;
  assign is_clr = instr.opcode == usprx_pkg::OP_CARRY_CLR;
  assign is_ret = instr.opcode == usprx_pkg::OP_PROC_RET;
  // Requests seen while busy are dropped; the fetch path waits for done.
  assign start = instr_valid && !busy_r && (is_down || is_up || is_clr
    || is_ret);
  assign last_cyc = cyc_r == cyc_len_r - 4'h1;
  // RL1 RL3 pointer step
  assign ptr_new = (ins_r.opcode == usprx_pkg::OP_PUSH_DOWN) ?
    rd_data - 8'h01 : rd_data + 8'h01;

  // Read address follows state; pointer, then source operand.
  // A source equal to the pointer register reads the stepped pointer.
  assign rd_addr = (state_r == usprx_pkg::ST_PTR_RD) ? ins_r.dst : ins_r.src;

  // One write port serves the pointer write-back and the data store.
  always_comb
  begin
    wr = '0;
    if (state_r == usprx_pkg::ST_PTR_WB)
    begin
      // RL1 RL3 pointer written back
      wr.we = 1'b1;
      wr.addr = ins_r.dst;
      wr.data = ptr_new;
    end
    else if (state_r == usprx_pkg::ST_DATA_WR)
    begin
      // RL2 RL4 store at pointer
      wr.we = 1'b1;
      wr.addr = ptr_r;
      wr.data = rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      usprx_pkg::ST_IDLE:
        if (start)
          state_nxt = (is_down || is_up) ? usprx_pkg::ST_PTR_RD :
            is_ret ? usprx_pkg::ST_RET_HI : usprx_pkg::ST_WAIT;
      usprx_pkg::ST_PTR_RD: state_nxt = usprx_pkg::ST_PTR_WB;
      usprx_pkg::ST_PTR_WB: state_nxt = usprx_pkg::ST_SRC_RD;
      usprx_pkg::ST_SRC_RD: state_nxt = usprx_pkg::ST_DATA_WR;
      usprx_pkg::ST_DATA_WR: state_nxt = usprx_pkg::ST_WAIT;
      usprx_pkg::ST_RET_HI: state_nxt = usprx_pkg::ST_RET_LO;
      usprx_pkg::ST_RET_LO: state_nxt = usprx_pkg::ST_WAIT;
      usprx_pkg::ST_WAIT:
        if (last_cyc)
          state_nxt = usprx_pkg::ST_DONE;
      usprx_pkg::ST_DONE: state_nxt = usprx_pkg::ST_IDLE;
      default: state_nxt = usprx_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_r <= usprx_pkg::ST_IDLE;
      cyc_r <= 4'h0;
      cyc_len_r <= 4'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ins_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      done_r <= state_r == usprx_pkg::ST_DONE;
      if (state_r == usprx_pkg::ST_IDLE && start)
      begin
        ins_r <= instr;
        busy_r <= 1'b1;
        cyc_r <= 4'h1;
        // RL9 return length
        cyc_len_r <= is_ret ? (stack_external ? usprx_pkg::CYC_RET_EXT :
          usprx_pkg::CYC_RET_INT) : is_clr ? usprx_pkg::CYC_CLR :
          usprx_pkg::CYC_PUSH;
      end
      // Busy drops on the done edge, so a new take can follow at once.
      else if (state_r == usprx_pkg::ST_DONE)
      begin
        busy_r <= 1'b0;
      end
      else if (busy_r && !last_cyc)
      begin
        cyc_r <= cyc_r + 4'h1;
      end
    end
  end

  // The instruction occupies cyc_len cycles counted from the start edge.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      flags_r <= usprx_pkg::FLAGS_RST;
      pc_r <= usprx_pkg::PC_RST;
      sp_r <= usprx_pkg::SP_RST;
      ptr_r <= 8'h00;
      ret_hi_r <= 8'h00;
      stk_addr_r <= 16'h0000;
      fetch_r <= 1'b0;
    end
    else
    begin
      fetch_r <= 1'b0;
      // A carry clear needs no datapath, so it only waits out its length.
      // RL6 carry forced low
      if (state_r == usprx_pkg::ST_IDLE && start && is_clr)
        flags_r[usprx_pkg::FLAG_CARRY_POS] <= 1'b0;
      if (state_r == usprx_pkg::ST_PTR_WB)
        ptr_r <= ptr_new;
      // RL7 high byte at SP
      if (state_r == usprx_pkg::ST_IDLE && start && is_ret)
        stk_addr_r <= sp_r;
      // The stack answer is taken combinationally, one address a cycle.
      if (state_r == usprx_pkg::ST_RET_HI)
      begin
        ret_hi_r <= stack_rd_data;
        // RL10 low byte above
        stk_addr_r <= sp_r + 16'h0001;
      end
      if (state_r == usprx_pkg::ST_RET_LO)
      begin
        pc_r <= {ret_hi_r, stack_rd_data};
        // RL7 pointer plus two
        sp_r <= sp_r + usprx_pkg::SP_RET_STEP;
      end
      // RL8 fetch from new PC
      if (state_r == usprx_pkg::ST_DONE &&
          ins_r.opcode == usprx_pkg::OP_PROC_RET)
        fetch_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RL5 flags untouched otherwise
  assign flags = flags_r;
  assign pc = pc_r;
  assign sp = sp_r;
  assign busy = busy_r;
  assign done = done_r;
  assign fetch_req = fetch_r;
  assign fetch_addr = pc_r;
  assign stack_rd_addr = stk_addr_r;
  assign rf_dbg_data = ptr_r;

  ////////////////////////////////////////////////////////////////////////
  // The register file is cleared at reset, so user stacks start known.
  usprx_regfile u_rf
  (
    .clk(sys_clk),
    .rst(sys_rst),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
endmodule // usprx_exec

// file: logic/usprx_pkg.sv
// Package with opcodes, cycle counts and carrier structs for the exec block.
package usprx_pkg;
  localparam logic [7:0] OP_PUSH_DOWN = 8'h82;
  localparam logic [7:0] OP_PUSH_UP = 8'h83;
  localparam logic [7:0] OP_CARRY_CLR = 8'hcf;
  localparam logic [7:0] OP_PROC_RET = 8'haf;
  localparam logic [3:0] CYC_PUSH = 4'h8;
  localparam logic [3:0] CYC_CLR = 4'h4;
  localparam logic [3:0] CYC_RET_INT = 4'h8;
  localparam logic [3:0] CYC_RET_EXT = 4'ha;
  localparam logic [15:0] SP_RET_STEP = 16'h0002;
  localparam int FLAG_CARRY_POS = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst;
    logic [7:0] src;
  } usprx_instr_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } usprx_rf_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PTR_RD = 4'b0001,
    ST_PTR_WB = 4'b0011,
    ST_SRC_RD = 4'b0010,
    ST_DATA_WR = 4'b0110,
    ST_RET_HI = 4'b0111,
    ST_RET_LO = 4'b0101,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1100
  } usprx_state_t;
endpackage

// file: logic/usprx_regfile.sv
// Register file with one write port and one registered read port.
`timescale 1ns/1ps
module usprx_regfile
(
  input wire logic clk,
  input wire logic rst,
  input wire usprx_pkg::usprx_rf_wr_t wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:255];

  // Clearing every word at reset trades flops for known user stacks.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 256; i++)
      begin
        mem[i] <= 8'h00;
      end
    end
    else if (wr.we)
    begin
      mem[wr.addr] <= wr.data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // usprx_regfile

// file: verif/usprx_exec_monitor.sv
// Port checker for the exec block.
`timescale 1ns/1ps
module usprx_exec_monitor
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire usprx_pkg::usprx_instr_t instr,
  input wire logic stack_external,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] flags,
  input wire logic [15:0] pc,
  input wire logic [15:0] sp,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] stack_rd_addr
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic go;
  logic ret;
  logic [15:0] sp_at_r;
  assign go = instr_valid && !busy;
  assign ret = go && instr.opcode == usprx_pkg::OP_PROC_RET;
  // The pointer is kept so later cycles can be tied to the take.
  always_ff @(posedge sys_clk)
    if (ret)
      sp_at_r <= sp;
  AST_FLAGS_KEEP: assert property (
    go && instr.opcode != usprx_pkg::OP_CARRY_CLR |=> $stable(flags)[*8])
    else $error("flags moved");
  AST_CARRY_ZERO: assert property (
    go && instr.opcode == usprx_pkg::OP_CARRY_CLR |-> ##[1:8] !flags[7])
    else $error("carry not cleared");
  AST_SP_STEP: assert property (
    ret |-> ##[1:16] sp == sp_at_r + 16'h0002)
    else $error("stack pointer step wrong");
  AST_HI_ADDR: assert property (
    ret |-> ##[1:4] stack_rd_addr == sp_at_r)
    else $error("high byte address wrong");
  AST_LO_ADDR: assert property (
    ret |-> ##[2:6] stack_rd_addr == sp_at_r + 16'h0001)
    else $error("low byte address wrong");
  AST_FETCH_ADDR: assert property (
    fetch_req |-> fetch_addr == pc)
    else $error("fetch address wrong");
  AST_RET_FETCH: assert property (
    ret |-> ##[6:16] fetch_req)
    else $error("no fetch after return");
  AST_DONE_PULSE: assert property (
    done |=> !done)
    else $error("done too long");
  AST_PUSH_LEN: assert property (
    go && (instr.opcode == usprx_pkg::OP_PUSH_DOWN ||
      instr.opcode == usprx_pkg::OP_PUSH_UP) |=> busy[*8] ##1 !busy)
    else $error("push length wrong");
  AST_CLR_LEN: assert property (
    go && instr.opcode == usprx_pkg::OP_CARRY_CLR |=> busy[*4] ##1 !busy)
    else $error("carry clear length wrong");
  AST_RET_LEN: assert property (
    ret && !stack_external |=> busy[*8] ##1 !busy)
    else $error("return length wrong");
  AST_RET_LEN_EXT: assert property (
    ret && stack_external |=> busy[*8] ##1 busy[*2] ##1 !busy)
    else $error("long return length wrong");
endmodule // usprx_exec_monitor

bind usprx_exec usprx_exec_monitor u_usprx_exec_monitor (.*);

// file: verif/usprx_stack_model.sv
// Stack memory model with a combinational read answer.
`timescale 1ns/1ps
module usprx_stack_model
(
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  assign data = addr[7:0] ^ 8'h5a;
endmodule // usprx_stack_model

// file: verif/usprx_exec_tb.sv
// Testbench for the exec block.
`timescale 1ns/1ps
module usprx_exec_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  usprx_pkg::usprx_instr_t instr = '0;
  logic stack_external = 1'b0;
  logic [7:0] stack_rd_data, flags, rf_dbg_data;
  logic busy, done, fetch_req;
  logic [15:0] pc, sp, fetch_addr, stack_rd_addr;
  int failures = 0;
  int n_tests = 0;
  int len, len_a;
  always #10 sys_clk = ~sys_clk;
  usprx_exec u_usprx_exec (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr(instr), .busy(busy), .done(done),
    .stack_external(stack_external), .stack_rd_data(stack_rd_data),
    .flags(flags), .pc(pc), .sp(sp), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .stack_rd_addr(stack_rd_addr),
    .rf_dbg_data(rf_dbg_data));
  usprx_stack_model u_usprx_stack_model (.addr(stack_rd_addr),
    .data(stack_rd_data));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One instruction, counted until its done pulse.
  task automatic run(input logic [7:0] op, input logic [7:0] d,
    input logic [7:0] s);
    instr_valid = 1'b1;
    instr = {op, d, s};
    @(posedge sys_clk);
    #1 instr_valid = 1'b0;
    len = 0;
    while (done !== 1'b1 && len < 40)
    begin
      @(posedge sys_clk);
      #1 len++;
    end
    if (len == 40)
    begin
      failures++;
      conclude();
    end
  endtask
  task automatic sc_ret();
    run(usprx_pkg::OP_PROC_RET, 8'h00, 8'h00);
    len_a = len;
    chk(16'(len), 16'h0008);
    chk(pc, 16'h5a5b);
    chk(sp, 16'h0002);
    chk({15'h0, fetch_req}, 16'h0001);
    chk(fetch_addr, 16'h5a5b);
    chk({8'h0, flags}, 16'h0000);
    stack_external = 1'b1;
    run(usprx_pkg::OP_PROC_RET, 8'h00, 8'h00);
    stack_external = 1'b0;
    chk(pc, 16'h5859);
    chk(sp, 16'h0004);
    chk(16'(len - len_a), 16'h0002);
  endtask
  // The register file starts cleared, so every pointer value is known.
  task automatic sc_push();
    run(usprx_pkg::OP_PUSH_UP, 8'h10, 8'h20);
    chk({8'h0, rf_dbg_data}, 16'h0001);
    chk(16'(len), 16'h0008);
    run(usprx_pkg::OP_PUSH_UP, 8'h20, 8'h10);
    chk({8'h0, rf_dbg_data}, 16'h0001);
    run(usprx_pkg::OP_PUSH_DOWN, 8'h01, 8'h10);
    chk({8'h0, rf_dbg_data}, 16'h0000);
    chk(16'(len), 16'h0008);
    run(usprx_pkg::OP_PUSH_UP, 8'h00, 8'h30);
    chk({8'h0, rf_dbg_data}, 16'h0002);
    run(usprx_pkg::OP_PUSH_DOWN, 8'h40, 8'h30);
    chk({8'h0, rf_dbg_data}, 16'h00ff);
    chk({8'h0, flags}, 16'h0000);
    run(usprx_pkg::OP_CARRY_CLR, 8'h00, 8'h00);
    chk(16'(len), 16'h0004);
    chk({8'h0, flags}, 16'h0000);
  endtask
  // An opcode outside the set must not start anything.
  task automatic sc_refuse();
    instr_valid = 1'b1;
    instr = '0;
    @(posedge sys_clk);
    #1 instr_valid = 1'b0;
    chk({15'h0, busy}, 16'h0000);
    chk(sp, 16'h0004);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    sc_ret();
    sc_push();
    sc_refuse();
    conclude();
  end
endmodule // usprx_exec_tb
